// ===== verilog/rx_filter_and_image_calibration.sv
`timescale 1ns/1ps
module rx_filter_and_image_calibration
  import rx_cal_pkg::*;
#(
  parameter int unsigned COARSE_CNT = COARSE_CYCLES,
  parameter int unsigned DWELL_CNT = DWELL_CYCLES,
  parameter int unsigned ITER_MAX = FINE_ITER_MAX
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Calibration start write
  input wire logic cal_write,
  input wire logic coarse_cal_bit,
  input wire logic fine_cal_enable,
  // Filter setup
  input wire logic [1:0] filter_bandwidth_select,
  input wire logic [TRIM_W-1:0] filter_adjust,
  input wire logic filter_adjust_write,
  // Fine measurement result from strength detector: 1 means raise center
  input wire logic tone_upper_weaker,
  // Status select
  input wire logic [MUX_SEL_W-1:0] status_select,
  output logic muxed_status_output,
  // Readback
  input wire logic readback_req,
  output logic [READBACK_W-1:0] readback_word,
  // Image calibration
  input wire logic internal_source_enable,
  input wire logic [HARM_W-1:0] tone_harmonic,
  input wire logic [11:0] iq_adjust,
  output logic [11:0] iq_adjust_out,
  output logic lna_enable,
  output logic tone_to_mixer,
  output logic [HARM_W:0] tone_multiple,
  // Filter trim and state
  output logic [TRIM_W-1:0] filter_trim,
  output logic [1:0] filter_bw_out,
  output logic cal_busy
);
  cal_state_t state_ff, nxt_state;
  logic done_ff;
  logic fine_valid_ff;
  logic [TRIM_W-1:0] trim_ff;
  logic [ITER_W-1:0] iter_ff;
  logic [READBACK_W-1:0] rb_ff;
  logic [11:0] iq_ff;
  logic tmr_load;
  logic [19:0] tmr_val;
  wire logic tmr_exp;

  wire logic start = cal_write && coarse_cal_bit;
  // Starts during a run are refused and must not disturb the flags
  wire logic start_taken = start && !cal_busy;
  wire logic last_iter = (iter_ff == ITER_W'(ITER_MAX - 1));
  wire logic fine_active = (state_ff == ST_FINE_ADJ) || (state_ff == ST_FINE_MEAS);
  wire logic trim_at_top = (trim_ff == {TRIM_W{1'b1}});
  wire logic trim_at_bot = (trim_ff == '0);

  dwell_timer #(.CNT_W(20)) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_exp)
  );

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    tmr_load = 1'b0;
    tmr_val = 20'(COARSE_CNT);
    case (state_ff)
      ST_IDLE, ST_DONE: begin
        if (start) begin
          nxt_state = ST_COARSE;
          tmr_load = 1'b1;
        end
      end
      ST_COARSE: begin
        if (tmr_exp) begin
          if (fine_cal_enable) begin
            nxt_state = ST_FINE_ADJ;
          end else begin
            nxt_state = ST_DONE;
          end
        end
      end
      ST_FINE_ADJ: begin
        nxt_state = ST_FINE_MEAS;
        tmr_load = 1'b1;
        tmr_val = 20'(DWELL_CNT);
      end
      ST_FINE_MEAS: begin
        if (tmr_exp) begin
          nxt_state = last_iter ? ST_DONE : ST_FINE_ADJ;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      done_ff <= 1'b0;
      iter_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (start_taken) begin
        done_ff <= 1'b0;
      end else if (nxt_state == ST_DONE && state_ff != ST_DONE) begin
        done_ff <= 1'b1;
      end
      if (state_ff == ST_COARSE) begin
        iter_ff <= '0;
      end else if (state_ff == ST_FINE_MEAS && tmr_exp && !last_iter) begin
        iter_ff <= iter_ff + 1'b1;
      end
    end
  end

  // Filter center trim: manual write or fine step adjustment
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_ff <= TRIM_RESET;
      fine_valid_ff <= 1'b0;
    end else begin
      if (state_ff == ST_FINE_MEAS && tmr_exp) begin
        if (tone_upper_weaker && !trim_at_top) begin
          trim_ff <= trim_ff + 1'b1;
        end else if (!tone_upper_weaker && !trim_at_bot) begin
          trim_ff <= trim_ff - 1'b1;
        end
      end else if (filter_adjust_write && !fine_active) begin
        trim_ff <= filter_adjust;
      end
      if (start_taken) begin
        fine_valid_ff <= 1'b0;
      end else if (state_ff == ST_FINE_MEAS && tmr_exp && last_iter) begin
        fine_valid_ff <= 1'b1;
      end
    end
  end

  // Readback and image adjust holding
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rb_ff <= '0;
      iq_ff <= '0;
    end else begin
      if (readback_req) begin
        rb_ff <= fine_valid_ff ? READBACK_W'({1'b0, fine_valid_ff, trim_ff}) : '0;
      end
      if (cal_write) begin
        iq_ff <= iq_adjust;
      end
    end
  end

  // Status mux
  assign muxed_status_output = (status_select == MUX_SEL_CAL_DONE) ? done_ff :
                               (status_select == MUX_SEL_HIGH);
  assign readback_word = rb_ff;
  assign iq_adjust_out = iq_ff;
  assign filter_trim = trim_ff;
  assign filter_bw_out = filter_bandwidth_select;
  assign cal_busy = (state_ff != ST_IDLE) && (state_ff != ST_DONE);
  assign lna_enable = !fine_active && !internal_source_enable;
  assign tone_to_mixer = internal_source_enable;
  assign tone_multiple = {tone_harmonic, 1'b1};
endmodule

// ===== shared/rx_cal_pkg.sv
package rx_cal_pkg;
  // Core clock rate
  localparam int unsigned CLK_HZ = 25000000;
  // Coarse calibration time, microseconds
  localparam int unsigned COARSE_TIME_US = 200;
  localparam int unsigned COARSE_CYCLES = (COARSE_TIME_US * (CLK_HZ / 1000000));
  // One tone dwell (adjust plus strength measurement), microseconds
  localparam int unsigned DWELL_TIME_US = 800;
  localparam int unsigned DWELL_CYCLES = (DWELL_TIME_US * (CLK_HZ / 1000000));
  // Largest number of fine iterations
  localparam int unsigned FINE_ITER_MAX = 10;
  localparam int unsigned ITER_W = 4;
  // Fine trim width and reset value
  localparam int unsigned TRIM_W = 6;
  localparam logic [5:0] TRIM_RESET = 6'h20;
  // Status output select codes
  localparam int unsigned MUX_SEL_W = 3;
  localparam logic [2:0] MUX_SEL_LOW = 3'h0;
  localparam logic [2:0] MUX_SEL_CAL_DONE = 3'h5;
  localparam logic [2:0] MUX_SEL_HIGH = 3'h7;
  // Readback word width
  localparam int unsigned READBACK_W = 16;
  // Tone harmonic select width
  localparam int unsigned HARM_W = 4;
  typedef enum logic [2:0] {ST_IDLE, ST_COARSE, ST_FINE_ADJ, ST_FINE_MEAS, ST_DONE} cal_state_t;
endpackage

// ===== verilog/dwell_timer.sv
`timescale 1ns/1ps
module dwell_timer
  import rx_cal_pkg::*;
#(
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // Status
  output logic expired
);
  logic [CNT_W-1:0] cnt_ff;
  logic busy_ff;
  wire logic at_end = busy_ff && (cnt_ff == '0);
  wire logic [CNT_W-1:0] nxt_cnt = load ? load_val - 1'b1 : (busy_ff ? cnt_ff - 1'b1 : cnt_ff);

  // Counts down and pulses when the loaded span is used up
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= at_end && !load ? cnt_ff : nxt_cnt;
      busy_ff <= load | (busy_ff & ~at_end);
    end
  end

  assign expired = at_end && !load;
endmodule

// ===== testbench/rx_cal_props.sv
`timescale 1ns/1ps
module rx_cal_props
  import rx_cal_pkg::*;
#(
  parameter int COARSE_CNT = 20
) (
  input wire logic core_clk, rst_b, cal_write, coarse_cal_bit, fine_cal_enable,
  input wire logic internal_source_enable, filter_adjust_write, cal_busy,
  input wire logic lna_enable, tone_to_mixer, muxed_status_output,
  input wire logic [2:0] status_select,
  input wire logic [3:0] tone_harmonic,
  input wire logic [4:0] tone_multiple,
  input wire logic [5:0] filter_adjust, filter_trim
);
  localparam int CEND = COARSE_CNT + 4;
  localparam int FINE_AT = COARSE_CNT;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_mux_high: assert property (status_select == MUX_SEL_HIGH |-> muxed_status_output)
    else $error("high select code not high");
  a_done_low: assert property (cal_busy && status_select == MUX_SEL_CAL_DONE
    |-> !muxed_status_output) else $error("done shown while busy");
  a_start_busy: assert property (cal_write && coarse_cal_bit && !cal_busy |=> cal_busy)
    else $error("start not taken");
  a_coarse_first: assert property ($rose(cal_busy) && !internal_source_enable
    |-> lna_enable [*8]) else $error("amplifier cut before coarse step");
  a_coarse_end: assert property ($rose(cal_busy) && !fine_cal_enable
    |-> cal_busy [*8] ##[1:CEND] !cal_busy) else $error("coarse run length wrong");
  a_lna_back: assert property ($fell(cal_busy) && !internal_source_enable |-> lna_enable)
    else $error("amplifier not rejoined");
  a_fine_detach: assert property ($rose(cal_busy) && fine_cal_enable && !internal_source_enable
    |-> ##FINE_AT (!lna_enable) [*8]) else $error("amplifier not detached in fine step");
  a_int_src: assert property (internal_source_enable |-> !lna_enable && tone_to_mixer)
    else $error("internal tone path wrong");
  a_tone_odd: assert property (tone_multiple == {tone_harmonic, 1'b1})
    else $error("tone multiple not odd");
  a_trim_load: assert property (filter_adjust_write && !cal_busy
    |=> filter_trim == $past(filter_adjust)) else $error("manual trim not applied");
  c_cal_end: cover property ($fell(cal_busy));
  c_fine_run: cover property (cal_busy && !lna_enable);
  c_trim: cover property (filter_adjust_write);
endmodule

// ===== testbench/rx_cal_host.sv
`timescale 1ns/1ps
module rx_cal_host (
  // Clock and status
  input wire logic core_clk,
  input wire logic cal_busy,
  // Calibration writes and readback
  output logic cal_write = 1'b0,
  output logic coarse_cal_bit = 1'b0,
  output logic fine_cal_enable = 1'b0,
  output logic readback_req = 1'b0
);
  // Fine chosen by caller when bandwidth margin is short
  task automatic start(input logic fine);
    @(posedge core_clk);
    fine_cal_enable <= fine;
    cal_write <= 1'b1;
    coarse_cal_bit <= 1'b1;
    @(posedge core_clk);
    cal_write <= 1'b0;
    coarse_cal_bit <= 1'b0;
    repeat (2000) begin
      @(negedge core_clk);
      if (!cal_busy) break;
    end
  endtask
  task automatic rd();
    @(posedge core_clk);
    readback_req <= 1'b1;
    @(posedge core_clk);
    readback_req <= 1'b0;
    @(negedge core_clk);
  endtask
endmodule

// ===== testbench/tb_rx_filter_and_image_calibration.sv
`timescale 1ns/1ps
module tb_rx_filter_and_image_calibration
  import rx_cal_pkg::*;
;
  logic core_clk, rst_b, cal_write, coarse_cal_bit, fine_cal_enable, filter_adjust_write;
  logic tone_upper_weaker, internal_source_enable, muxed_status_output, lna_enable;
  logic tone_to_mixer, cal_busy, readback_req;
  logic [1:0] filter_bandwidth_select, filter_bw_out;
  logic [5:0] filter_adjust, filter_trim;
  logic [2:0] status_select;
  logic [3:0] tone_harmonic;
  logic [4:0] tone_multiple;
  logic [11:0] iq_adjust, iq_adjust_out;
  logic [15:0] readback_word;
  int mismatches, n_compared;
  rx_filter_and_image_calibration #(.COARSE_CNT(20), .DWELL_CNT(30), .ITER_MAX(10))
    u_rx_filter_and_image_calibration (.core_clk, .rst_b, .cal_write, .coarse_cal_bit,
    .fine_cal_enable, .filter_bandwidth_select, .filter_adjust, .filter_adjust_write,
    .tone_upper_weaker, .status_select, .muxed_status_output, .readback_req, .readback_word,
    .internal_source_enable, .tone_harmonic, .iq_adjust, .iq_adjust_out, .lna_enable,
    .tone_to_mixer, .tone_multiple, .filter_trim, .filter_bw_out, .cal_busy);
  rx_cal_host u_rx_cal_host (.core_clk, .cal_busy, .cal_write, .coarse_cal_bit,
    .fine_cal_enable, .readback_req);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    results();
  end
  initial begin
    {rst_b, filter_adjust_write, tone_upper_weaker, internal_source_enable} = 4'h0;
    {filter_bandwidth_select, filter_adjust, tone_harmonic, iq_adjust} = 24'h0;
    status_select = MUX_SEL_CAL_DONE;
    repeat (8) @(posedge core_clk);
    rst_b <= 1'b1;
    iq_adjust <= 12'h5a3;
    filter_bandwidth_select <= 2'h2;
    tone_upper_weaker <= 1'b1;
    @(negedge core_clk);
    chk(filter_trim, 16'h20);
    chk(muxed_status_output, 16'h0);
    u_rx_cal_host.rd();
    chk(readback_word, 16'h0);
    u_rx_cal_host.start(1'b0);
    chk(muxed_status_output, 16'h1);
    chk(iq_adjust_out, 16'h5a3);
    chk(filter_bw_out, 16'h2);
    fork
      u_rx_cal_host.start(1'b1);
      begin
        repeat (10) @(negedge core_clk);
        chk(cal_busy, 16'h1);
        chk(lna_enable, 16'h1);
        chk(muxed_status_output, 16'h0);
        repeat (20) @(negedge core_clk);
        chk(lna_enable, 16'h0);
      end
    join
    chk(filter_trim, 16'h2a);
    chk(lna_enable, 16'h1);
    u_rx_cal_host.rd();
    chk(readback_word, 16'h006a);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      status_select <= 3'(i);
      @(negedge core_clk);
      chk(muxed_status_output, 16'(i == 5 || i == 7));
    end
    @(posedge core_clk);
    filter_adjust <= 6'h15;
    filter_adjust_write <= 1'b1;
    @(posedge core_clk);
    filter_adjust_write <= 1'b0;
    internal_source_enable <= 1'b1;
    tone_harmonic <= 4'h6;
    @(negedge core_clk);
    chk(filter_trim, 16'h15);
    chk({lna_enable, tone_to_mixer, tone_multiple}, 16'h2d);
    repeat (2) @(negedge core_clk);
    chk(filter_trim, 16'h15);
    chk(cal_busy, 16'h0);
    results();
  end
endmodule
bind rx_filter_and_image_calibration rx_cal_props #(.COARSE_CNT(COARSE_CNT)) u_rx_cal_props (
  .core_clk, .rst_b, .cal_write, .coarse_cal_bit, .fine_cal_enable, .internal_source_enable,
  .filter_adjust_write, .cal_busy, .lna_enable, .tone_to_mixer, .muxed_status_output,
  .status_select, .tone_harmonic, .tone_multiple, .filter_adjust, .filter_trim);
